// [core/sync_rx_pkg.sv]
// constants, register map and carrier types for the synchronous serial receiver
package sync_rx_pkg;

    // register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFS_SERIAL_MODE       = 8'h00;
    localparam logic [7:0] OFS_BIT_RATE_DIVISOR  = 8'h04;
    localparam logic [7:0] OFS_BIT_ORDER_CONTROL = 8'h08;
    localparam logic [7:0] OFS_SERIAL_STATUS     = 8'h0C;
    localparam logic [7:0] OFS_RX_DATA_REG       = 8'h10;
    localparam logic [7:0] OFS_SERIAL_CONTROL    = 8'h14;

    // reset values
    localparam logic [7:0] RST_SERIAL_MODE       = 8'h00;
    localparam logic [7:0] RST_BIT_RATE_DIVISOR  = 8'hFF;
    localparam logic [7:0] RST_BIT_ORDER_CONTROL = 8'hF2;
    localparam logic [7:0] RST_SERIAL_STATUS     = 8'h84;
    localparam logic [7:0] RST_SERIAL_CONTROL    = 8'h00;
    localparam logic [7:0] RST_BYTE_ZERO         = 8'h00;

    // serial_mode fields
    localparam int MODE_COMM_MODE      = 7;
    localparam int MODE_MULTIPROC_MODE = 2;
    localparam int MODE_CLOCK_SEL_HI   = 1;
    localparam int MODE_CLOCK_SEL_LO   = 0;
    localparam logic [1:0] CLOCK_SEL_PERIPH = 2'b00;

    // bit_order_control field
    localparam int ORDER_MSB_FIRST = 3;

    // serial_control fields
    localparam int CTRL_RECEIVE_ENABLE = 4;
    localparam int CTRL_CLOCK_EXT      = 1;

    // serial_status fields
    localparam int ST_TX_DATA_EMPTY     = 7;
    localparam int ST_RX_DATA_FULL      = 6;
    localparam int ST_OVERRUN_ERROR     = 5;
    localparam int ST_FRAMING_ERROR     = 4;
    localparam int ST_PARITY_ERROR      = 3;
    localparam int ST_TX_END            = 2;
    localparam int ST_MULTIPROC_RX_BIT  = 1;
    localparam int ST_MULTIPROC_TX_BIT  = 0;

    // prescaler limits for the four clock select codes
    localparam logic [5:0] PRE_LIMIT_DIV1  = 6'h00;
    localparam logic [5:0] PRE_LIMIT_DIV4  = 6'h03;
    localparam logic [5:0] PRE_LIMIT_DIV16 = 6'h0F;
    localparam logic [5:0] PRE_LIMIT_DIV64 = 6'h3F;

    localparam logic [3:0] BITS_PER_CHAR = 4'h8;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avs_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } avs_rsp_t;

    typedef struct packed {
        logic sck;
        logic sck_oe_b;
    } serial_pins_t;

    typedef enum logic [0:0] {RX_IDLE, RX_SHIFT} rx_state_t;

endpackage

// [core/bit_rate_gen.sv]
// baud-rate generator: prescaler plus 8-bit divisor, one-cycle tick out
`timescale 1ns/1ns
module bit_rate_gen
    import sync_rx_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_run,
    input  wire logic [1:0] i_clock_select,
    input  wire logic [7:0] i_divisor,
    output logic            o_tick
);

    typedef struct packed {
        logic [5:0] pre_cnt;
        logic [7:0] div_cnt;
        logic       tick;
    } brg_state_t;

    brg_state_t st;
    brg_state_t next_st;

    function automatic logic [5:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'b00:   pre_limit = PRE_LIMIT_DIV1;
            2'b01:   pre_limit = PRE_LIMIT_DIV4;
            2'b10:   pre_limit = PRE_LIMIT_DIV16;
            default: pre_limit = PRE_LIMIT_DIV64;
        endcase
    endfunction

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (!i_run) begin
            next_st.pre_cnt = '0;
            next_st.div_cnt = '0;
        end else if (st.pre_cnt >= pre_limit(i_clock_select)) begin
            // select 00 gives a prescaler of one: peripheral clock direct
            next_st.pre_cnt = '0;
            if (st.div_cnt >= i_divisor) begin
                next_st.div_cnt = '0;
                next_st.tick    = 1'b1;
            end else begin
                next_st.div_cnt = st.div_cnt + 8'h01;
            end
        end else begin
            next_st.pre_cnt = st.pre_cnt + 6'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;

endmodule

// [core/sync_serial_receiver.sv]
// clock-synchronous serial receiver with Avalon-MM register slave
`timescale 1ns/1ns
// What this block does
// - clock select 00 feeds generator from clock
// - 8-bit divisor register sets bit rate
// - order bit 3: 0 lsb first, 1 msb
// - multiprocessor mode ignored in synchronous operation
// - status holds six flags and two multiprocessor bits
// - writing 0 clears flag, 1 leaves it; the two transmit flags stay one
// - only hardware sets status flags to one
// - internal clock runs until receive enable clears or communication mode bit 7 is set to 1
// - communication mode bit 7 at 0 selects synchronous
// - full character moves to data, sets full; with full or overrun already set it sets overrun instead
module sync_serial_receiver
    import sync_rx_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire avs_req_t    i_avs,
    output avs_rsp_t         o_avs,
    input  wire logic        i_sck,
    input  wire logic        i_rxd,
    output serial_pins_t     o_pins,
    output logic             o_rx_active
);

    typedef struct packed {
        logic [7:0]   serial_mode;
        logic [7:0]   bit_rate_divisor;
        logic [7:0]   bit_order_control;
        logic [7:0]   serial_control;
        logic [7:0]   serial_status;
        logic [7:0]   rx_data_reg;
        logic [7:0]   rx_shift_reg;
        logic [3:0]   bit_cnt;
        rx_state_t    rx_state;
        logic         sck_ext_prev;
        logic         rx_active;
        serial_pins_t pins;
        avs_rsp_t     rsp;
    } rx_state_all_t;

    rx_state_all_t st;
    rx_state_all_t next_st;
    logic          brg_tick;
    logic          sync_mode;
    logic          internal_clock;
    logic          rx_run;

    // register read multiplexer
    function automatic logic [31:0] reg_read(input rx_state_all_t s, input logic [7:0] addr);
        case (addr)
            OFS_SERIAL_MODE:       reg_read = {24'h00_0000, s.serial_mode};
            OFS_BIT_RATE_DIVISOR:  reg_read = {24'h00_0000, s.bit_rate_divisor};
            OFS_BIT_ORDER_CONTROL: reg_read = {24'h00_0000, s.bit_order_control};
            OFS_SERIAL_STATUS:     reg_read = {24'h00_0000, s.serial_status};
            OFS_RX_DATA_REG:       reg_read = {24'h00_0000, s.rx_data_reg};
            OFS_SERIAL_CONTROL:    reg_read = {24'h00_0000, s.serial_control};
            default:               reg_read = READ_ZERO;
        endcase
    endfunction

    // insert one received bit in the chosen order
    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic bit_in, input logic msb_first);
        if (msb_first) begin
            shift_in = {sr[6:0], bit_in};
        end else begin
            shift_in = {bit_in, sr[7:1]};
        end
    endfunction

    assign sync_mode      = ~st.serial_mode[MODE_COMM_MODE];
    assign internal_clock = ~st.serial_control[CTRL_CLOCK_EXT];
    assign rx_run         = sync_mode & st.serial_control[CTRL_RECEIVE_ENABLE];

    bit_rate_gen u_brg (
        .i_clk          (i_clk),
        .i_rst_b        (i_rst_b),
        .i_run          (rx_run & internal_clock),
        .i_clock_select ({st.serial_mode[MODE_CLOCK_SEL_HI], st.serial_mode[MODE_CLOCK_SEL_LO]}),
        .i_divisor      (st.bit_rate_divisor),
        .o_tick         (brg_tick)
    );

    always_comb begin
        logic        acc;
        logic        wr_now;
        logic        sample;
        logic        char_done;
        logic [7:0]  wd;
        logic [7:0]  shifted;
        logic        set_full;
        logic        set_over;
        acc       = 1'b0;
        wr_now    = 1'b0;
        sample    = 1'b0;
        char_done = 1'b0;
        wd        = i_avs.writedata[7:0];
        shifted   = st.rx_shift_reg;
        set_full  = 1'b0;
        set_over  = 1'b0;
        next_st   = st;

        // bus slave: one wait cycle, answer at the edge where waitrequest is low
        acc    = i_avs.read | i_avs.write;
        wr_now = i_avs.write & ~st.rsp.waitrequest & i_avs.byteenable[0];
        if (acc && st.rsp.waitrequest) begin
            next_st.rsp.waitrequest = 1'b0;
            next_st.rsp.readdata    = reg_read(st, i_avs.address);
        end else begin
            next_st.rsp.waitrequest = 1'b1;
        end

        // serial clock: internal toggles on generator ticks, external is edge-detected
        next_st.sck_ext_prev = i_sck;
        if (rx_run && internal_clock) begin
            if (brg_tick) begin
                next_st.pins.sck = ~st.pins.sck;
                sample           = ~st.pins.sck;
            end
        end else begin
            next_st.pins.sck = 1'b1;
            if (rx_run) begin
                sample = i_sck & ~st.sck_ext_prev;
            end
        end
        next_st.pins.sck_oe_b = ~(sync_mode & internal_clock);

        // receive shifter; multiprocessor mode plays no part here
        if (!rx_run) begin
            next_st.rx_state = RX_IDLE;
            next_st.bit_cnt  = '0;
        end else begin
            case (st.rx_state)
                RX_IDLE: begin
                    next_st.rx_state = RX_SHIFT;
                    next_st.bit_cnt  = '0;
                end
                RX_SHIFT: begin
                    if (sample) begin
                        shifted              = shift_in(st.rx_shift_reg, i_rxd,
                                                        st.bit_order_control[ORDER_MSB_FIRST]);
                        next_st.rx_shift_reg = shifted;
                        if (st.bit_cnt == BITS_PER_CHAR - 4'h1) begin
                            next_st.bit_cnt = '0;
                            char_done       = 1'b1;
                        end else begin
                            next_st.bit_cnt = st.bit_cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    next_st.rx_state = RX_IDLE;
                end
            endcase
        end
        next_st.rx_active = rx_run;

        if (char_done) begin
            if (st.serial_status[ST_RX_DATA_FULL] || st.serial_status[ST_OVERRUN_ERROR]) begin
                set_over = 1'b1;
            end else begin
                next_st.rx_data_reg = shifted;
                set_full            = 1'b1;
            end
        end

        // register writes
        if (wr_now) begin
            case (i_avs.address)
                OFS_SERIAL_MODE:       next_st.serial_mode       = wd;
                OFS_BIT_RATE_DIVISOR:  next_st.bit_rate_divisor  = wd;
                OFS_BIT_ORDER_CONTROL: next_st.bit_order_control = wd;
                OFS_SERIAL_CONTROL:    next_st.serial_control    = wd;
                OFS_SERIAL_STATUS: begin
                    // flags: a 0 clears, a 1 keeps; software cannot set
                    next_st.serial_status[ST_TX_DATA_EMPTY:ST_TX_END] = st.serial_status[ST_TX_DATA_EMPTY:ST_TX_END]
                                                                      & wd[ST_TX_DATA_EMPTY:ST_TX_END];
                    next_st.serial_status[ST_MULTIPROC_TX_BIT] = wd[ST_MULTIPROC_TX_BIT];
                end
                default: begin
                end
            endcase
        end

        // hardware sets win over a clear in the same cycle
        if (set_full) begin
            next_st.serial_status[ST_RX_DATA_FULL] = 1'b1;
        end
        if (set_over) begin
            next_st.serial_status[ST_OVERRUN_ERROR] = 1'b1;
        end
        // no transmitter: its flags stay set; no framing or parity in this mode
        next_st.serial_status[ST_TX_DATA_EMPTY]    = 1'b1;
        next_st.serial_status[ST_TX_END]           = 1'b1;
        next_st.serial_status[ST_FRAMING_ERROR]    = st.serial_status[ST_FRAMING_ERROR]
                                                     & next_st.serial_status[ST_FRAMING_ERROR];
        next_st.serial_status[ST_PARITY_ERROR]     = st.serial_status[ST_PARITY_ERROR]
                                                     & next_st.serial_status[ST_PARITY_ERROR];
        next_st.serial_status[ST_MULTIPROC_RX_BIT] = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st                   <= '0;
            st.serial_mode       <= RST_SERIAL_MODE;
            st.bit_rate_divisor  <= RST_BIT_RATE_DIVISOR;
            st.bit_order_control <= RST_BIT_ORDER_CONTROL;
            st.serial_control    <= RST_SERIAL_CONTROL;
            st.serial_status     <= RST_SERIAL_STATUS;
            st.rx_data_reg       <= RST_BYTE_ZERO;
            st.rx_state          <= RX_IDLE;
            st.sck_ext_prev      <= 1'b1;
            st.pins.sck          <= 1'b1;
            st.pins.sck_oe_b     <= 1'b1;
            st.rsp.waitrequest   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_avs       = st.rsp;
    assign o_pins      = st.pins;
    assign o_rx_active = st.rx_active;

endmodule

// [dv/sync_serial_receiver_assertions.sv]
// port checks for the synchronous serial receiver
`timescale 1ns/1ns
module sync_serial_receiver_assertions
    import sync_rx_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire avs_req_t     i_avs,
    input  wire avs_rsp_t     o_avs,
    input  wire logic         i_sck,
    input  wire logic         i_rxd,
    input  wire serial_pins_t o_pins,
    input  wire logic         o_rx_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic wr_ok;
    assign wr_ok = i_avs.write && !o_avs.waitrequest && i_avs.byteenable[0];
    property p_answer; (i_avs.read || i_avs.write) && o_avs.waitrequest |=> !o_avs.waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");
    property p_wr_pulse; !o_avs.waitrequest |=> o_avs.waitrequest; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("waitrequest low too long");
    property p_upper; !o_avs.waitrequest |-> o_avs.readdata[31:8] == 24'h00_0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read lanes not zero");
    property p_rd_stable; o_avs.waitrequest && $past(o_avs.waitrequest) |-> $stable(o_avs.readdata); endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved while idle");
    property p_tx_ones;
        i_avs.read && i_avs.address == OFS_SERIAL_STATUS && !o_avs.waitrequest
            |-> o_avs.readdata[ST_TX_DATA_EMPTY] && o_avs.readdata[ST_TX_END];
    endproperty
    a_tx_ones: assert property (p_tx_ones) else $error("transmit flags not one");
    logic        sck_q;
    logic [15:0] still_cnt;
    // cycles since the driven serial clock last moved; slowest legal half period is 256 x 64
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_q     <= 1'b1;
            still_cnt <= 16'h0000;
        end else begin
            sck_q <= o_pins.sck;
            if (!o_rx_active || o_pins.sck_oe_b || (o_pins.sck != sck_q)) begin
                still_cnt <= 16'h0000;
            end else begin
                still_cnt <= still_cnt + 16'h0001;
            end
        end
    end
    property p_sck_runs;
        still_cnt <= 16'h4010;
    endproperty
    a_sck_runs: assert property (p_sck_runs) else $error("serial clock stalled");
    property p_sck_idle; !o_rx_active [*4] |-> o_pins.sck; endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("serial clock not idle high");
    property p_re_clear;
        wr_ok && i_avs.address == OFS_SERIAL_CONTROL && !i_avs.writedata[CTRL_RECEIVE_ENABLE] |-> ##2 !o_rx_active;
    endproperty
    a_re_clear: assert property (p_re_clear) else $error("receiver still active");
    property p_async_off;
        wr_ok && i_avs.address == OFS_SERIAL_MODE && i_avs.writedata[MODE_COMM_MODE]
            |-> ##2 (!o_rx_active && o_pins.sck_oe_b);
    endproperty
    a_async_off: assert property (p_async_off) else $error("async mode still synchronous");
endmodule

// [dv/sync_tx_model.sv]
// far-side synchronous transmitter, new bit after each serial clock fall
`timescale 1ns/1ns
module sync_tx_model (
    input  wire logic       i_clk,
    input  wire logic       i_run,
    input  wire logic       i_ext,
    input  wire logic       i_msb,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_sck_dev,
    output logic            o_sck,
    output logic            o_rxd
);
    logic [7:0] cur = 8'h00;
    logic [2:0] k   = 3'h0;
    logic [1:0] div = 2'h0;
    logic       prev = 1'b1;
    logic [7:0] src;
    logic       sck_now;
    initial o_sck = 1'b1;
    initial o_rxd = 1'b1;
    assign src = (k == 3'h0) ? i_byte : cur;
    assign sck_now = i_ext ? o_sck : i_sck_dev;
    always @(posedge i_clk) begin
        div <= div + 2'h1;
        prev <= sck_now;
        if (!i_run) begin
            o_sck <= 1'b1;
            k <= 3'h0;
            o_rxd <= ~o_rxd;
        end else begin
            if (i_ext && div == 2'h3) o_sck <= ~o_sck;
            if (prev && !sck_now) begin
                o_rxd <= src[i_msb ? 3'h7 - k : k];
                if (k == 3'h0) cur <= i_byte;
                k <= k + 3'h1;
            end
        end
    end
endmodule

// [dv/sync_serial_receiver_tb_top.sv]
// self-checking bench for the synchronous serial receiver
`timescale 1ns/1ns
module sync_serial_receiver_tb_top
    import sync_rx_pkg::*;
;
    logic         clk;
    logic         rst_b;
    avs_req_t     req;
    avs_rsp_t     rsp;
    serial_pins_t pins;
    logic         sck_ext, rxd, active, ext, msb;
    logic [7:0]   tx_byte, v, u;
    logic [7:0]   ofs [7];
    logic [7:0]   rvl [7];
    int           errors = 0;
    int           total_checks = 0;
    int           seed = 7554;
    sync_serial_receiver u_sync_serial_receiver (.i_clk(clk), .i_rst_b(rst_b), .i_avs(req), .o_avs(rsp),
        .i_sck(sck_ext), .i_rxd(rxd), .o_pins(pins), .o_rx_active(active));
    sync_tx_model u_sync_tx_model (.i_clk(clk), .i_run(active), .i_ext(ext), .i_msb(msb), .i_byte(tx_byte),
        .i_sck_dev(pins.sck), .o_sck(sck_ext), .o_rxd(rxd));
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        req.read <= !w;
        req.write <= w;
        req.address <= a;
        req.writedata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 100);
        q = rsp.readdata[7:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
        if (n >= 100) begin
            chk("waitrequest", 8'h00, 8'h01);
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk($sformatf("reg_%h", a), e, q);
    endtask
    task automatic wait_full();
        logic [7:0] q;
        int n;
        q = 8'h00;
        n = 0;
        while (q[ST_RX_DATA_FULL] !== 1'b1 && n < 300) begin
            bus(1'b0, OFS_SERIAL_STATUS, 8'h00, q);
            n++;
        end
        chk("rx_data_full", 8'h01, {7'h00, q[ST_RX_DATA_FULL]});
        if (q[ST_RX_DATA_FULL] !== 1'b1) close_out();
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #600000;
        errors++;
        close_out();
    end
    initial begin
        req = '0;
        req.byteenable = 4'h1;
        rst_b = 1'b0;
        ext = 1'b0;
        msb = 1'b0;
        tx_byte = 8'h00;
        ofs = '{OFS_SERIAL_MODE, OFS_BIT_RATE_DIVISOR, OFS_BIT_ORDER_CONTROL, OFS_SERIAL_STATUS,
                OFS_RX_DATA_REG, OFS_SERIAL_CONTROL, 8'h18};
        rvl = '{RST_SERIAL_MODE, RST_BIT_RATE_DIVISOR, RST_BIT_ORDER_CONTROL, RST_SERIAL_STATUS,
                RST_BYTE_ZERO, RST_SERIAL_CONTROL, 8'h00};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(ofs[i], rvl[i]);
        v = 8'($random(seed));
        wr(OFS_BIT_RATE_DIVISOR, v);
        rd_chk(OFS_BIT_RATE_DIVISOR, v);
        wr(8'h18, v);
        rd_chk(8'h18, 8'h00);
        wr(OFS_SERIAL_STATUS, 8'hFF);
        rd_chk(OFS_SERIAL_STATUS, 8'h85);
        wr(OFS_SERIAL_MODE, 8'h80);
        wr(OFS_SERIAL_CONTROL, 8'h10);
        repeat (4) @(posedge clk);
        chk("rx_active", 8'h00, {7'h00, active});
        wr(OFS_SERIAL_CONTROL, 8'h00);
        wr(OFS_SERIAL_MODE, 8'h04);
        rd_chk(OFS_SERIAL_MODE, 8'h04);
        wr(OFS_BIT_RATE_DIVISOR, 8'h07);
        for (int m = 0; m < 2; m++) begin
            v = 8'($random(seed));
            u = {v[7:1], ~v[7]};
            msb <= m[0];
            tx_byte <= u;
            wr(OFS_BIT_ORDER_CONTROL, m[0] ? 8'hFA : 8'hF2);
            wr(OFS_SERIAL_MODE, m[0] ? 8'h04 : 8'h05);
            wr(OFS_SERIAL_CONTROL, 8'h10);
            wait_full();
            rd_chk(OFS_RX_DATA_REG, u);
            wr(OFS_SERIAL_STATUS, 8'hBF);
            rd_chk(OFS_SERIAL_STATUS, 8'h85);
            if (m == 0) wr(OFS_SERIAL_CONTROL, 8'h00);
        end
        repeat (20) @(posedge clk);
        v = 8'($random(seed));
        tx_byte <= v;
        repeat (300) @(posedge clk);
        rd_chk(OFS_SERIAL_STATUS, 8'hE5);
        rd_chk(OFS_RX_DATA_REG, u);
        wr(OFS_SERIAL_STATUS, 8'hBF);
        repeat (300) @(posedge clk);
        rd_chk(OFS_SERIAL_STATUS, 8'hA5);
        wr(OFS_SERIAL_STATUS, 8'hDF);
        wait_full();
        rd_chk(OFS_RX_DATA_REG, v);
        wr(OFS_SERIAL_CONTROL, 8'h00);
        wr(OFS_SERIAL_STATUS, 8'h9F);
        ext <= 1'b1;
        v = 8'($random(seed));
        tx_byte <= v;
        wr(OFS_SERIAL_CONTROL, 8'h12);
        wait_full();
        chk("sck_oe_b", 8'h01, {7'h00, pins.sck_oe_b});
        rd_chk(OFS_RX_DATA_REG, v);
        close_out();
    end
endmodule
bind sync_serial_receiver sync_serial_receiver_assertions u_sync_serial_receiver_assertions (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs(i_avs), .o_avs(o_avs), .i_sck(i_sck), .i_rxd(i_rxd),
    .o_pins(o_pins), .o_rx_active(o_rx_active));
